//--- sim/gpc_pin_model.sv
`timescale 1ns/1ps
module gpc_pin_model import gpc_pkg::*; #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire gpc_pad_type pad,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin_i
);
  logic [W-1:0] float_q = '0;

  // a floating pin wanders every cycle so a stale level never passes
  always @(posedge core_clk) begin
    float_q <= ~float_q;
  end

  // resolve each pin: own driver, outside driver, pullup, else floating
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pad.oe[i]) pin_i[i] = pad.o[i];
      else if (ext_en[i]) pin_i[i] = ext_val[i];
      else if (pad.pull[i]) pin_i[i] = 1'b1;
      else pin_i[i] = float_q[i];
    end
  end
endmodule : gpc_pin_model

//--- sim/gpc_tb.sv
`timescale 1ns/1ps
module tb import gpc_pkg::*;;
  localparam logic [5:0] CL = GPC_PORT_C_LATCH_IDX;
  localparam logic [5:0] DL = GPC_PORT_D_LATCH_IDX;
  localparam logic [5:0] CD = GPC_PORT_C_DIRECTION_IDX;
  localparam logic [5:0] DD = GPC_PORT_D_DIRECTION_IDX;
  localparam logic [5:0] CP = GPC_PORT_C_PULL_ENABLE_IDX;
  localparam logic [5:0] DP = GPC_PORT_D_PULL_ENABLE_IDX;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [3:0] sel_lanes = 4'h1;
  gpc_wb_req_type wb_req = '0;
  gpc_wb_rsp_type wb_rsp;
  gpc_pad_type port_c_pad;
  gpc_pad_type port_d_pad;
  logic [3:0] port_c_pin_i;
  logic [3:0] c_val = 4'h0;
  logic [3:0] c_en = 4'h0;
  logic [7:0] port_d_pin_i;
  logic [7:0] d_val = 8'h00;
  logic [7:0] d_en = 8'h00;
  int miscompares = 0;
  int comparisons = 0;

  gpc_top uut (.core_clk(core_clk), .resetn(resetn), .ce(ce), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .port_c_pin_i(port_c_pin_i), .port_d_pin_i(port_d_pin_i),
    .port_c_pad(port_c_pad), .port_d_pad(port_d_pad));
  gpc_pin_model #(.W(4)) pins_c (.core_clk(core_clk), .pad(port_c_pad), .ext_val(c_val),
    .ext_en(c_en), .pin_i(port_c_pin_i));
  gpc_pin_model #(.W(8)) pins_d (.core_clk(core_clk), .pad(port_d_pad), .ext_val(d_val),
    .ext_en(d_en), .pin_i(port_d_pin_i));

  // clock
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one classic cycle, held until ack is sampled high
  task automatic xfer(input logic we, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: sel_lanes,
                dat: {24'h00_0000, wd}};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    rd = wb_rsp.dat;
    if (n >= 50) miscompares++;
    wb_req <= '0;
  endtask : xfer

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    xfer(1'b1, idx, wd, rd);
  endtask : wr

  task automatic rdchk(input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] rd;
    xfer(1'b0, idx, 8'h00, rd);
    check($sformatf("read %h", idx), rd, {24'h00_0000, e});
  endtask : rdchk

  task automatic padchk(input string what, input logic [7:0] s, input logic [7:0] e);
    check(what, {24'h00_0000, s}, {24'h00_0000, e});
  endtask : padchk

  task automatic ext(input logic [3:0] cv, input logic [3:0] ce_n, input logic [7:0] dv,
                     input logic [7:0] de);
    @(posedge core_clk);
    c_val <= cv;
    c_en <= ce_n;
    d_val <= dv;
    d_en <= de;
  endtask : ext

  // watchdog
  initial begin
    #100000;
    miscompares++;
    close_out();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rdchk(CD, 8'h00);
    rdchk(DD, 8'h00);
    rdchk(CP, 8'h00);
    rdchk(DP, 8'h00);
    padchk("d oe", port_d_pad.oe, 8'h00);
    ext(4'h5, 4'hf, 8'h3c, 8'hff);
    wr(DL, 8'ha5);
    rdchk(DL, 8'h3c);
    ext(4'h5, 4'hf, 8'h3c, 8'hf0);
    wr(DD, 8'h0f);
    padchk("d oe", port_d_pad.oe, 8'h0f);
    padchk("d o", port_d_pad.o, 8'ha5);
    rdchk(DL, 8'h35);
    ext(4'h5, 4'hf, 8'h3c, 8'h00);
    wr(DP, 8'hff);
    padchk("d pull", port_d_pad.pull, 8'hf0);
    rdchk(DL, 8'hf5);
    wr(DP, 8'h00);
    padchk("d pull", port_d_pad.pull, 8'h00);
    wr(CL, 8'h0f);
    rdchk(CL, 8'h05);
    ext(4'h0, 4'h8, 8'h00, 8'h00);
    wr(CD, 8'hff);
    rdchk(CD, 8'h07);
    padchk("c oe", port_c_pad.oe, 8'h07);
    padchk("c o", port_c_pad.o, 8'h07);
    rdchk(CL, 8'h07);
    ext(4'h8, 4'h8, 8'h00, 8'h00);
    rdchk(CL, 8'h0f);
    ext(4'h0, 4'h0, 8'h00, 8'h00);
    wr(CP, 8'hff);
    rdchk(CP, 8'h0f);
    padchk("c pull", port_c_pad.pull, 8'h08);
    wr(CD, 8'h00);
    padchk("c pull", port_c_pad.pull, 8'h0f);
    rdchk(CL, 8'h0f);
    wr(6'h3f, 8'hff);
    rdchk(6'h3f, 8'h00);
    wr(CD, 8'h07);
    wr(DD, 8'hff);
    // second reset in mid-run
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    padchk("c oe", port_c_pad.oe, 8'h00);
    padchk("d oe", port_d_pad.oe, 8'h00);
    padchk("c pull", port_c_pad.pull, 8'h00);
    padchk("d o", port_d_pad.o, 8'ha5);
    padchk("c o", port_c_pad.o, 8'h07);
    wr(DD, 8'hff);
    rdchk(DL, 8'ha5);
    // byte lane 0 off: answered but nothing written
    sel_lanes = 4'h2;
    wr(DL, 8'h00);
    sel_lanes = 4'h1;
    rdchk(DL, 8'ha5);
    // low clock enable holds off the answer and the write
    @(posedge core_clk);
    ce <= 1'b0;
    fork
      wr(DL, 8'h5a);
      begin
        repeat (4) @(posedge core_clk);
        check("ack frozen", {31'h0000_0000, wb_rsp.ack}, 32'h0000_0000);
        padchk("d o frozen", port_d_pad.o, 8'ha5);
        ce <= 1'b1;
      end
    join
    padchk("d o", port_d_pad.o, 8'h5a);
    rdchk(DL, 8'h5a);
    close_out();
  end
endmodule : tb

//--- verilog/gpc_pkg.sv
// Notes on behaviour
// - Port C has four pins; the top pin is input only and the lower three are each in or out.
// - Bit 3 of the port C data register is read only and returns the input-only pin level.
// - The three port C data latch bits are read/write and keep their value across reset.
// - A port C direction bit of one enables that pin driver, zero makes the pin an input.
// - Reset clears all port C direction bits so every port C pin starts as an input.
// - Reading port C data gives the latch for output pins and the pin level for input pins.
// - Data writes with byte lane 0 selected load the latch; on input pins they do not change the value read.
// - Each port C pull enable turns the pullup on only while that pin is an input.
// - A cleared pull enable bit keeps the pullup off whatever the direction, on both ports.
// - Port D has eight bidirectional pins, each with latch, direction and pull enable bits.
// - The eight port D latch bits are read/write and are left unchanged by reset.
// - A port D direction bit of one enables the driver; reset clears all eight bits.
// - Reading port D data gives the latch for output pins and the pin level for input pins.
// - Each port D pull enable turns the pullup on only while that pin is an input.
package gpc_pkg;

  // widths
  localparam int GPC_C_W = 4;
  localparam int GPC_D_W = 8;
  localparam int GPC_C_OUT_W = 3;
  localparam int GPC_IDX_W = 6;

  // register indices, byte address is four times the index
  localparam logic [5:0] GPC_PORT_C_LATCH_IDX = 6'h02;
  localparam logic [5:0] GPC_PORT_D_LATCH_IDX = 6'h03;
  localparam logic [5:0] GPC_PORT_C_DIRECTION_IDX = 6'h06;
  localparam logic [5:0] GPC_PORT_D_DIRECTION_IDX = 6'h07;
  localparam logic [5:0] GPC_PORT_C_PULL_ENABLE_IDX = 6'h0b;
  localparam logic [5:0] GPC_PORT_D_PULL_ENABLE_IDX = 6'h0c;

  // field positions
  localparam int GPC_ADR_IDX_LSB = 2;
  localparam int GPC_INPUT_ONLY_BIT = 3;

  // values after reset
  localparam logic [2:0] GPC_DIR_C_RST = 3'h0;
  localparam logic [7:0] GPC_DIR_D_RST = 8'h00;
  localparam logic [3:0] GPC_PUE_C_RST = 4'h0;
  localparam logic [7:0] GPC_PUE_D_RST = 8'h00;
  localparam logic [31:0] GPC_RDAT_RST = 32'h0000_0000;

  // classic wishbone request and answer
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } gpc_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } gpc_wb_rsp_type;

  // pad drive toward the pins, low bits used by the narrow port
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pull;
  } gpc_pad_type;

  // bus access sequencer states
  typedef enum logic [1:0] {
    GPC_IDLE = 2'b01,
    GPC_ACK = 2'b10
  } gpc_fsm_type;

  // register index match from a byte address
  function automatic logic gpc_hit(input logic [7:0] adr, input logic [5:0] idx);
    gpc_hit = (adr[7:GPC_ADR_IDX_LSB] == idx);
  endfunction : gpc_hit

endpackage : gpc_pkg

//--- verilog/gpc_port_pins.sv
`timescale 1ns/1ps
module gpc_port_pins import gpc_pkg::*; #(
  parameter int W = 8
) (
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] pue,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] pull,
  output logic [W-1:0] rd_val
);

  // one pad cell per pin
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign pin_o[i] = latch[i];
    assign pin_oe[i] = dir[i];
    assign pull[i] = pue[i] & ~dir[i];
    assign rd_val[i] = dir[i] ? latch[i] : pin_i[i];
  end

endmodule : gpc_port_pins

//--- verilog/gpc_top.sv
`timescale 1ns/1ps
module gpc_top import gpc_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire gpc_wb_req_type wb_req,
  output gpc_wb_rsp_type wb_rsp,
  input wire logic [3:0] port_c_pin_i,
  input wire logic [7:0] port_d_pin_i,
  output gpc_pad_type port_c_pad,
  output gpc_pad_type port_d_pad
);

  // all registered state of the port pair
  typedef struct packed {
    logic [2:0] latch_c;
    logic [7:0] latch_d;
    logic [2:0] dir_c;
    logic [7:0] dir_d;
    logic [3:0] pue_c;
    logic [7:0] pue_d;
    logic [31:0] rdat;
  } gpc_top_state_type;

  gpc_top_state_type s_q;
  gpc_top_state_type s_d;

  logic take;
  logic ack;
  logic wr_en;
  logic [3:0] c_dir_full;
  logic [3:0] c_latch_full;
  logic [3:0] c_pin_o;
  logic [3:0] c_pin_oe;
  logic [3:0] c_pull;
  logic [3:0] c_rd;
  logic [7:0] d_pin_o;
  logic [7:0] d_pin_oe;
  logic [7:0] d_pull;
  logic [7:0] d_rd;
  logic [7:0] rd_byte;

  // bus sequencer
  gpc_wb_ack u_ack (
    .core_clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .req_valid(wb_req.cyc && wb_req.stb),
    .take(take),
    .ack(ack)
  );

  // input-only pin has no driver and no latch
  assign c_dir_full = {1'b0, s_q.dir_c};
  assign c_latch_full = {1'b0, s_q.latch_c};

  gpc_port_pins #(.W(GPC_C_W)) u_port_c (
    .latch(c_latch_full),
    .dir(c_dir_full),
    .pue(s_q.pue_c),
    .pin_i(port_c_pin_i),
    .pin_o(c_pin_o),
    .pin_oe(c_pin_oe),
    .pull(c_pull),
    .rd_val(c_rd)
  );

  gpc_port_pins #(.W(GPC_D_W)) u_port_d (
    .latch(s_q.latch_d),
    .dir(s_q.dir_d),
    .pue(s_q.pue_d),
    .pin_i(port_d_pin_i),
    .pin_o(d_pin_o),
    .pin_oe(d_pin_oe),
    .pull(d_pull),
    .rd_val(d_rd)
  );

  // pad outputs, unused upper lanes of port c held low
  assign port_c_pad.o = {4'h0, c_pin_o};
  assign port_c_pad.oe = {4'h0, c_pin_oe};
  assign port_c_pad.pull = {4'h0, c_pull};
  assign port_d_pad.o = d_pin_o;
  assign port_d_pad.oe = d_pin_oe;
  assign port_d_pad.pull = d_pull;

  // bus answer
  assign wb_rsp.ack = ack;
  assign wb_rsp.dat = s_q.rdat;
  assign wr_en = take && wb_req.we && wb_req.sel[0];

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_byte = 8'h00;
    if (gpc_hit(wb_req.adr, GPC_PORT_C_LATCH_IDX)) begin
      rd_byte = {4'h0, c_rd};
    end else if (gpc_hit(wb_req.adr, GPC_PORT_D_LATCH_IDX)) begin
      rd_byte = d_rd;
    end else if (gpc_hit(wb_req.adr, GPC_PORT_C_DIRECTION_IDX)) begin
      rd_byte = {5'h00, s_q.dir_c};
    end else if (gpc_hit(wb_req.adr, GPC_PORT_D_DIRECTION_IDX)) begin
      rd_byte = s_q.dir_d;
    end else if (gpc_hit(wb_req.adr, GPC_PORT_C_PULL_ENABLE_IDX)) begin
      rd_byte = {4'h0, s_q.pue_c};
    end else if (gpc_hit(wb_req.adr, GPC_PORT_D_PULL_ENABLE_IDX)) begin
      rd_byte = s_q.pue_d;
    end
  end

  // register writes and read capture
  always_comb begin
    s_d = s_q;
    if (take) begin
      s_d.rdat = {24'h00_0000, rd_byte};
    end
    if (wr_en) begin
      if (gpc_hit(wb_req.adr, GPC_PORT_C_LATCH_IDX)) begin
        s_d.latch_c = wb_req.dat[2:0];
      end
      if (gpc_hit(wb_req.adr, GPC_PORT_D_LATCH_IDX)) begin
        s_d.latch_d = wb_req.dat[7:0];
      end
      if (gpc_hit(wb_req.adr, GPC_PORT_C_DIRECTION_IDX)) begin
        s_d.dir_c = wb_req.dat[2:0];
      end
      if (gpc_hit(wb_req.adr, GPC_PORT_D_DIRECTION_IDX)) begin
        s_d.dir_d = wb_req.dat[7:0];
      end
      if (gpc_hit(wb_req.adr, GPC_PORT_C_PULL_ENABLE_IDX)) begin
        s_d.pue_c = wb_req.dat[3:0];
      end
      if (gpc_hit(wb_req.adr, GPC_PORT_D_PULL_ENABLE_IDX)) begin
        s_d.pue_d = wb_req.dat[7:0];
      end
    end
  end

  // state register; the data latches have no reset on purpose
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q.dir_c <= GPC_DIR_C_RST;
      s_q.dir_d <= GPC_DIR_D_RST;
      s_q.pue_c <= GPC_PUE_C_RST;
      s_q.pue_d <= GPC_PUE_D_RST;
      s_q.rdat <= GPC_RDAT_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // helper for checks: a direction write has been seen since reset
  logic dir_c_wr_q;
  logic dir_d_wr_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dir_c_wr_q <= 1'b0;
      dir_d_wr_q <= 1'b0;
    end else if (wr_en && gpc_hit(wb_req.adr, GPC_PORT_C_DIRECTION_IDX)) begin
      dir_c_wr_q <= 1'b1;
    end else if (wr_en && gpc_hit(wb_req.adr, GPC_PORT_D_DIRECTION_IDX)) begin
      dir_d_wr_q <= 1'b1;
    end
  end

  // input-only pin never driven, lower pins follow direction; latch unknown until written
  property p_c_drive;
    @(posedge core_clk) disable iff (!resetn)
      port_c_pad.oe[GPC_INPUT_ONLY_BIT] == 1'b0 && port_c_pad.oe[2:0] == s_q.dir_c
      && (port_c_pad.o[2:0] & s_q.dir_c) == (s_q.latch_c & s_q.dir_c);
  endproperty
  a_c_drive: assert property (p_c_drive) else $error("port c drive wrong");

  // read of port c returns pin level on bit 3
  property p_c_top_bit;
    @(posedge core_clk) disable iff (!resetn)
      (take && !wb_req.we && gpc_hit(wb_req.adr, GPC_PORT_C_LATCH_IDX))
      ##1 ack |-> wb_rsp.dat[3] == $past(port_c_pin_i[3]);
  endproperty
  a_c_top_bit: assert property (p_c_top_bit) else $error("input-only bit read wrong");

  // port c latch changes only by a write to it
  property p_c_latch_hold;
    @(posedge core_clk) disable iff (!resetn)
      !(wr_en && gpc_hit(wb_req.adr, GPC_PORT_C_LATCH_IDX)) |=> $stable(s_q.latch_c);
  endproperty
  a_c_latch_hold: assert property (p_c_latch_hold) else $error("port c latch moved");

  // directions stay cleared from reset until software writes them
  property p_dir_reset;
    @(posedge core_clk) disable iff (!resetn)
      (!dir_c_wr_q |-> s_q.dir_c == 3'h0) and (!dir_d_wr_q |-> s_q.dir_d == 8'h00);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared");

  // port c read mixes latch and pin by direction
  property p_c_read;
    @(posedge core_clk) disable iff (!resetn)
      (take && !wb_req.we && gpc_hit(wb_req.adr, GPC_PORT_C_LATCH_IDX)) ##1 ack
      |-> wb_rsp.dat[2:0] == (($past(s_q.dir_c) & $past(s_q.latch_c))
      | (~$past(s_q.dir_c) & $past(port_c_pin_i[2:0])));
  endproperty
  a_c_read: assert property (p_c_read) else $error("port c read wrong");

  // a port d write loads the latch whatever the direction
  property p_d_write;
    @(posedge core_clk) disable iff (!resetn)
      (wr_en && gpc_hit(wb_req.adr, GPC_PORT_D_LATCH_IDX))
      |=> s_q.latch_d == $past(wb_req.dat[7:0]) && s_q.dir_d == $past(s_q.dir_d);
  endproperty
  a_d_write: assert property (p_d_write) else $error("port d latch not loaded");

  // pullups only on inputs with enable set
  property p_pull;
    @(posedge core_clk) disable iff (!resetn)
      port_c_pad.pull[3:0] == (s_q.pue_c & ~{1'b0, s_q.dir_c})
      && port_d_pad.pull == (s_q.pue_d & ~s_q.dir_d);
  endproperty
  a_pull: assert property (p_pull) else $error("pullup state wrong");

  // cleared enable keeps the pullup off
  property p_pull_off;
    @(posedge core_clk) disable iff (!resetn)
      (s_q.pue_d == 8'h00) |-> port_d_pad.pull == 8'h00 ##0 (port_c_pad.pull & ~{4'h0, s_q.pue_c})
      == 8'h00;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pullup without enable");

  // port d read mixes latch and pin by direction
  property p_d_read;
    @(posedge core_clk) disable iff (!resetn)
      (take && !wb_req.we && gpc_hit(wb_req.adr, GPC_PORT_D_LATCH_IDX)) ##1 ack
      |-> wb_rsp.dat == {24'h00_0000, ($past(s_q.dir_d) & $past(s_q.latch_d))
      | (~$past(s_q.dir_d) & $past(port_d_pin_i))};
  endproperty
  a_d_read: assert property (p_d_read) else $error("port d read wrong");

  // unimplemented port c direction bits read zero
  property p_c_dir_zero;
    @(posedge core_clk) disable iff (!resetn)
      (take && !wb_req.we && gpc_hit(wb_req.adr, GPC_PORT_C_DIRECTION_IDX))
      |=> wb_rsp.ack && wb_rsp.dat[31:3] == 29'h0000_0000;
  endproperty
  a_c_dir_zero: assert property (p_c_dir_zero) else $error("reserved bits not zero");

  // ack lasts one active cycle
  property p_ack_pulse;
    @(posedge core_clk) disable iff (!resetn)
      (ack && ce) |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

  // port d drives exactly its output lanes with the latch
  property p_d_drive;
    @(posedge core_clk) disable iff (!resetn)
      port_d_pad.oe == s_q.dir_d && (port_d_pad.o & s_q.dir_d) == (s_q.latch_d & s_q.dir_d);
  endproperty
  a_d_drive: assert property (p_d_drive) else $error("port d drive wrong");

  // a port c write loads the three latch bits whatever the direction
  property p_c_write;
    @(posedge core_clk) disable iff (!resetn)
      (wr_en && gpc_hit(wb_req.adr, GPC_PORT_C_LATCH_IDX))
      |=> s_q.latch_c == $past(wb_req.dat[2:0]) && s_q.dir_c == $past(s_q.dir_c);
  endproperty
  a_c_write: assert property (p_c_write) else $error("port c latch not loaded");

  // direction writes land in the direction registers
  property p_dir_write;
    @(posedge core_clk) disable iff (!resetn)
      ((wr_en && gpc_hit(wb_req.adr, GPC_PORT_C_DIRECTION_IDX))
      |=> s_q.dir_c == $past(wb_req.dat[2:0]))
      and ((wr_en && gpc_hit(wb_req.adr, GPC_PORT_D_DIRECTION_IDX))
      |=> s_q.dir_d == $past(wb_req.dat[7:0]));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not loaded");

  // every taken request is answered after the next edge
  property p_take_ack;
    @(posedge core_clk) disable iff (!resetn)
      take |=> ack;
  endproperty
  a_take_ack: assert property (p_take_ack) else $error("request not answered");

  // input-only pin pull follows its enable alone, spare lanes stay off
  property p_c_top_pull;
    @(posedge core_clk) disable iff (!resetn)
      port_c_pad.pull[GPC_INPUT_ONLY_BIT] == s_q.pue_c[GPC_INPUT_ONLY_BIT]
      && port_c_pad.oe[7:4] == 4'h0 && port_c_pad.pull[7:4] == 4'h0;
  endproperty
  a_c_top_pull: assert property (p_c_top_pull) else $error("input-only pull wrong");

  // any of the six register indices, for the unmapped read check
  logic adr_mapped;
  assign adr_mapped = gpc_hit(wb_req.adr, GPC_PORT_C_LATCH_IDX)
    || gpc_hit(wb_req.adr, GPC_PORT_D_LATCH_IDX)
    || gpc_hit(wb_req.adr, GPC_PORT_C_DIRECTION_IDX)
    || gpc_hit(wb_req.adr, GPC_PORT_D_DIRECTION_IDX)
    || gpc_hit(wb_req.adr, GPC_PORT_C_PULL_ENABLE_IDX)
    || gpc_hit(wb_req.adr, GPC_PORT_D_PULL_ENABLE_IDX);

  // unmapped reads answer zero
  property p_unmapped_zero;
    @(posedge core_clk) disable iff (!resetn)
      (take && !wb_req.we && !adr_mapped) |=> wb_rsp.dat == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  // read data stands until the next taken request
  property p_rdat_hold;
    @(posedge core_clk) disable iff (!resetn)
      !take |=> $stable(wb_rsp.dat);
  endproperty
  a_rdat_hold: assert property (p_rdat_hold) else $error("read data moved");

  // low clock enable freezes registers and the answer
  property p_ce_freeze;
    @(posedge core_clk) disable iff (!resetn)
      !ce |=> $stable(s_q.dir_c) && $stable(s_q.dir_d) && $stable(s_q.pue_c)
      && $stable(s_q.pue_d) && $stable(wb_rsp.dat) && $stable(ack);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while frozen");

endmodule : gpc_top

//--- verilog/gpc_wb_ack.sv
`timescale 1ns/1ps
module gpc_wb_ack import gpc_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic req_valid,
  output logic take,
  output logic ack
);

  typedef struct packed {
    gpc_fsm_type fsm;
  } gpc_ack_state_type;

  gpc_ack_state_type s_q;
  gpc_ack_state_type s_d;

  // a request is taken once, the answer follows one cycle later
  assign take = ce && (s_q.fsm == GPC_IDLE) && req_valid;
  assign ack = (s_q.fsm == GPC_ACK);

  // next state
  always_comb begin
    s_d = s_q;
    unique case (s_q.fsm)
      GPC_IDLE: begin
        if (req_valid) begin
          s_d.fsm = GPC_ACK;
        end
      end
      GPC_ACK: begin
        s_d.fsm = GPC_IDLE;
      end
      default: begin
        s_d.fsm = GPC_IDLE;
      end
    endcase
  end

  // state register, frozen while ce is low
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q.fsm <= GPC_IDLE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

endmodule : gpc_wb_ack
